// file: design/sscl_top.sv
// Serial switch control latch: shift register, latch, clear, chaining output,
// plus a small event buffer. Assumes pins are asynchronous to i_core_clk and
// that the shift clock runs well below the core clock.
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module sscl_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
  logic [AW-1:0]    wr_q;            // Write pointer
  logic [AW-1:0]    rd_q;            // Read pointer
  logic [AW:0]      cnt_q;           // Fill level
  logic             push;
  logic             pop;

  // Honest flags from the fill level; room while below full depth
  assign o_in_ready  = (cnt_q < (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointers and level
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      // Simultaneous push and pop leave the level alone
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage has no reset; empty slots are never read out
  always_ff @(posedge i_clk)
  begin
    if (i_clk_en && push)
      mem_q[wr_q] <= i_in_data;
  end

endmodule : sscl_fifo

// What this block does
// - Eight-stage shift register, one bit per clock
// - Shift only on shift clock rising edge
// - Latch transparent while load strobe low
// - Latch freezes at load strobe rising edge
// - Shifting leaves switches alone while strobe high
// - Serial output mirrors last stage
// - Clear overrides the latch at the switch outputs, opens all switches
// - Each switch follows its own bit only
module sscl_top (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  input  wire logic       i_serial_data,
  input  wire logic       i_shift_clk,
  input  wire logic       i_latch_load_n,
  input  wire logic       i_clear_all_input,
  output logic      [7:0] o_switch,
  output logic            o_serial_out,
  output logic            o_evt_ready
);

  sscl_pkg::sscl_state_t s_q;        // Registered state
  sscl_pkg::sscl_state_t s_d;        // Next state
  sscl_pkg::sscl_evt_t   evt_in;     // Event from the pins
  sscl_pkg::sscl_evt_t   evt_out;    // Event leaving the buffer
  logic                  evt_valid;  // A pin event this cycle
  logic                  in_ready;   // Buffer has room
  logic                  out_valid;  // Buffer holds an event
  logic                  out_ready;  // Drain side takes it
  logic                  clk_rise;   // Shift clock rising edge
  logic                  load_chg;   // Strobe level changed
  logic                  clearing;   // Synchronised clear

  // Edge detection reads only the second synchroniser stage
  assign clk_rise  = s_q.sync2[sscl_pkg::LANE_CLK] && !s_q.clk_prev;
  assign load_chg  = s_q.sync2[sscl_pkg::LANE_LOAD] != s_q.load_prev;
  assign clearing  = s_q.sync2[sscl_pkg::LANE_CLEAR];
  assign evt_valid = clk_rise || load_chg;
  // While clear holds, the drain stalls so events queue up behind it
  assign out_ready = !clearing;

  // Pack an event: shift first, then the new strobe level
  always_comb
  begin
    evt_in.shift    = clk_rise;
    evt_in.data_bit = s_q.sync2[sscl_pkg::LANE_DATA];
    evt_in.load_n   = s_q.sync2[sscl_pkg::LANE_LOAD];
  end

  // Keeps pin events in order between edge detection and the register
  sscl_fifo #(
    .WIDTH (sscl_pkg::EVT_WIDTH),
    .DEPTH (sscl_pkg::EVT_DEPTH)
  ) u_evt_fifo (
    .i_clk       (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (evt_valid),
    .o_in_ready  (in_ready),
    .i_in_data   (evt_in),
    .o_out_valid (out_valid),
    .i_out_ready (out_ready),
    .o_out_data  (evt_out)
  );

  // Next state
  always_comb
  begin
    s_d           = s_q;
    s_d.sync1     = {i_clear_all_input, i_latch_load_n, i_shift_clk, i_serial_data};
    s_d.sync2     = s_q.sync1;
    s_d.clk_prev  = s_q.sync2[sscl_pkg::LANE_CLK];
    s_d.load_prev = s_q.sync2[sscl_pkg::LANE_LOAD];
    s_d.ready     = in_ready;
    // Apply one buffered event
    if (out_valid && out_ready)
    begin
      if (evt_out.shift)
        s_d.shreg = {s_q.shreg[6:0], evt_out.data_bit};
      s_d.load_n = evt_out.load_n;
    end
    if (!s_d.load_n)
      s_d.latch = s_d.shreg;
    s_d.sw   = clearing ? sscl_pkg::SW_OPEN : s_d.latch;
    s_d.sout = s_d.shreg[sscl_pkg::LAST_STAGE];
  end

  // State register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      s_q       <= '0;
      s_q.shreg <= sscl_pkg::SR_RESET;
      s_q.latch <= sscl_pkg::LATCH_RESET;
      s_q.sw    <= sscl_pkg::SW_OPEN;
      s_q.sync1 <= sscl_pkg::SYNC_RESET;
      s_q.sync2 <= sscl_pkg::SYNC_RESET;
    end
    else if (i_clk_en)
      s_q <= s_d;
  end

  assign o_switch     = s_q.sw;
  assign o_serial_out = s_q.sout;
  assign o_evt_ready  = s_q.ready;

  // Checks: hold strobe level applied to latch in step with state
  // clear opens all
  clear_opens_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ($past(i_clk_en) && $past(clearing)) |-> (o_switch == 8'h00))
    else $error("switches not open under clear");

  chain_out_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_serial_out == s_q.shreg[7])
    else $error("serial output differs from last stage");

  latch_follow_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !s_q.load_n |-> (s_q.latch == s_q.shreg))
    else $error("latch not transparent");

  latch_hold_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ($past(s_q.load_n) && s_q.load_n) |-> $stable(s_q.latch))
    else $error("latch changed while strobe high");

  latch_freeze_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(s_q.load_n) |-> (s_q.latch == $past(s_q.latch)))
    else $error("latch moved at strobe rise");

  shift_dir_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && out_valid && out_ready && evt_out.shift)
      |=> (s_q.shreg[7:1] == $past(s_q.shreg[6:0])))
    else $error("shift direction wrong");

  shift_edge_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !(out_valid && out_ready && evt_out.shift) |=> $stable(s_q.shreg))
    else $error("shift without clock edge");

  switch_map_a : assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && !clearing) |=> (o_switch == s_q.latch))
    else $error("switch differs from latch");

endmodule : sscl_top

// file: design/sscl_pkg.sv
// Shared constants and types for the serial switch control latch.
// Assumes one core clock; all pins arrive asynchronously.
package sscl_pkg;

  // Channel count and shift register width
  localparam int unsigned NUM_SW     = 8;
  // Index of the last stage, driven onto the serial output
  localparam int unsigned LAST_STAGE = 7;
  // Event buffer depth and width
  localparam int unsigned EVT_DEPTH  = 4;
  localparam int unsigned EVT_WIDTH  = 3;

  // Reset values
  localparam logic [7:0] SR_RESET    = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SW_OPEN     = 8'h00;
  localparam logic [3:0] SYNC_RESET  = 4'h0;

  // Synchroniser lane positions
  localparam int unsigned LANE_DATA  = 0;
  localparam int unsigned LANE_CLK   = 1;
  localparam int unsigned LANE_LOAD  = 2;
  localparam int unsigned LANE_CLEAR = 3;

  // One pin event: optional shift plus the strobe level after it
  typedef struct packed {
    logic shift;      // A shift clock rising edge occurred
    logic data_bit;   // Serial data sampled with that edge
    logic load_n;     // Latch load strobe level after the event
  } sscl_evt_t;

  // Entire state of the top module
  typedef struct packed {
    logic [3:0] sync1;      // First synchroniser stage
    logic [3:0] sync2;      // Second synchroniser stage
    logic       clk_prev;   // Previous synchronised shift clock
    logic       load_prev;  // Previous synchronised load strobe
    logic [7:0] shreg;      // Serial shift register
    logic [7:0] latch;      // Switch latch
    logic       load_n;     // Strobe level as applied to the latch
    logic [7:0] sw;         // Switch drive, 1 closes
    logic       sout;       // Serial output
    logic       ready;      // Event buffer could take an event
  } sscl_state_t;

endpackage : sscl_pkg

// file: dv/sscl_ctrl_model.sv
// Controller model: drives serial data, shift clock, strobe and clear.
// Assumes the core clock; pins change 1 ns after its rising edge.
`timescale 1ns/1ps
module sscl_ctrl_model (
  input  wire logic i_core_clk,
  output logic      o_serial_data,
  output logic      o_shift_clk,
  output logic      o_latch_load_n,
  output logic      o_clear_all_input
);
  // Idle pins: clock low, strobe high
  initial
  begin
    o_serial_data     = 1'b0;
    o_shift_clk       = 1'b0;
    o_latch_load_n    = 1'b1;
    o_clear_all_input = 1'b0;
  end
  // Wait n core cycles, then step off the edge
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : idle
  // data held across edge
  // Clock stands 6 cycles high and low, above the 4-cycle minimum
  task automatic shift_bit(input logic b);
    o_serial_data = b;
    idle(2);
    o_shift_clk = 1'b1;
    idle(6);
    o_shift_clk = 1'b0;
    o_serial_data = ~b;  // Hold over: line no longer valid
    idle(6);
  endtask : shift_bit
  // strobe untouched during byte
  // First bit sent is bit 7, so it ends in stage 7
  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      shift_bit(v[i]);
  endtask : shift_byte
  // Strobe level, then one idle cycle
  task automatic set_load(input logic v);
    o_latch_load_n = v;
    idle(1);
  endtask : set_load
  // Clear level, then one idle cycle
  task automatic set_clear(input logic v);
    o_clear_all_input = v;
    idle(1);
  endtask : set_clear
endmodule : sscl_ctrl_model

// file: dv/tb_serial_switch_control_latch.sv
// Self-checking bench for the switch control latch.
// Assumes the controller model in dv/ and a 100 MHz core clock.
`timescale 1ns/1ps
module tb_serial_switch_control_latch;
  logic       i_core_clk  = 1'b0;
  logic       i_reset_n   = 1'b0;
  logic       sdata;          // Model to pins
  logic       sclk;
  logic       load_n;
  logic       clr;
  logic [7:0] o_switch;
  logic       o_serial_out;
  logic       o_evt_ready;
  logic       clk_en      = 1'b1;  // Low freezes the whole block
  int         bad_count   = 0;
  int         comparisons = 0;
  // Core clock, 10 ns period
  always #5 i_core_clk = ~i_core_clk;
  // Clock enable driven by the bench so freezing is exercised
  sscl_top u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
    .i_serial_data(sdata), .i_shift_clk(sclk), .i_latch_load_n(load_n),
    .i_clear_all_input(clr), .o_switch(o_switch), .o_serial_out(o_serial_out),
    .o_evt_ready(o_evt_ready));
  sscl_ctrl_model u_ctl (.i_core_clk(i_core_clk), .o_serial_data(sdata),
    .o_shift_clk(sclk), .o_latch_load_n(load_n), .o_clear_all_input(clr));
  // Compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Pipeline is 4 edges; 12 leaves room for a queued event
  task automatic settle;
    u_ctl.idle(12);
  endtask : settle
  // Counts, verdict, end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Byte shifted with strobe high, then loaded
  task automatic t_load;
    u_ctl.shift_byte(8'hA5);
    settle();
    check("switch", o_switch, 8'h00);
    u_ctl.set_load(1'b0);
    settle();
    check("switch", o_switch, 8'hA5);
    check("sout", {7'h00, o_serial_out}, 8'h01);
    u_ctl.set_load(1'b1);
  endtask : t_load
  // Latch frozen while a new byte goes in
  task automatic t_freeze;
    u_ctl.shift_byte(8'h3C);
    settle();
    check("switch", o_switch, 8'hA5);
    check("sout", {7'h00, o_serial_out}, 8'h00);
  endtask : t_freeze
  // Transparent latch follows a single shift
  task automatic t_flow;
    u_ctl.set_load(1'b0);
    settle();
    check("switch", o_switch, 8'h3C);
    u_ctl.shift_bit(1'b1);
    settle();
    check("switch", o_switch, 8'h79);
  endtask : t_flow
  // Clear forces open; five shifts overflow the 4-deep buffer
  task automatic t_clear;
    u_ctl.set_clear(1'b1);
    settle();
    check("switch", o_switch, 8'h00);
    for (int i = 0; i < 5; i++)
      u_ctl.shift_bit(1'b1);
    check("ready", {7'h00, o_evt_ready}, 8'h00);
    check("switch", o_switch, 8'h00);
    u_ctl.set_clear(1'b0);
    settle();
    check("switch", o_switch, 8'h9F);
    check("ready", {7'h00, o_evt_ready}, 8'h01);
  endtask : t_clear
  // Frozen block ignores pins; clear acts once enabled, latch survives it
  task automatic t_hold_en;
    clk_en = 1'b0;
    u_ctl.set_clear(1'b1);
    u_ctl.shift_bit(1'b0);
    check("switch", o_switch, 8'h9F);
    clk_en = 1'b1;
    settle();
    check("switch", o_switch, 8'h00);
    u_ctl.set_clear(1'b0);
    settle();
    check("switch", o_switch, 8'h9F);
    check("sout", {7'h00, o_serial_out}, 8'h01);
  endtask : t_hold_en
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end
  // Main sequence: reset 2 cycles, then scenarios
  initial
  begin
    u_ctl.idle(2);
    i_reset_n = 1'b1;
    settle();
    check("switch", o_switch, 8'h00);
    check("ready", {7'h00, o_evt_ready}, 8'h01);
    t_load();
    t_freeze();
    t_flow();
    t_clear();
    t_hold_en();
    final_report();
  end
endmodule : tb_serial_switch_control_latch
